// ---- hw/ifcb_bank.sv ----
// interrupt flag bank: trap status, vector/edge control, three flag registers, wishbone slave
`timescale 1ns/1ps

// Function
// - alternate-vector bit selects alternate vector table
// - read-only bit 14 shows timed disable
// - per-pin polarity: one falling, zero rising
// - unimplemented bits always read as zero
// - address fault trap bit set on trap
// - stack fault trap bit set on trap
// - clock loss trap bit; bit 0 unused
// - flag reads one once source requested
// - flags read/write, zero after reset
// - flags 0 upper byte peripheral order
// - flags 0 lower byte peripheral order
// - flags 1 upper byte peripheral order
// - flags 1 lower byte peripheral order
// - flags 2 upper byte peripheral order
// - flags 2 lower byte peripheral order
module ifcb_bank
  import ifcb_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [SEL_W-1:0] WB_SEL_I,
  input wire logic [DATA_W-1:0] WB_DAT_I,
  input wire ifcb_flags_s PERIPH_EVT_I,
  input wire ifcb_trap_s TRAP_EVT_I,
  input wire logic TIMED_DISABLE_I,
  input wire logic [EXT_N-1:0] EXT_IRQ_PIN_I,
  output logic [DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ_O,
  output logic ALT_VECTOR_SEL_O,
  output logic [EXT_N-1:0] EXT_EDGE_O,
  output ifcb_flags_s FLAGS_O,
  output ifcb_trap_s TRAP_FLAGS_O
);

  // merge a byte-enabled write into a 16-bit register, hardware set wins
  function automatic logic [REG_W-1:0] merge_wr(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] wd,
    input logic [1:0] be,
    input logic wr,
    input logic [REG_W-1:0] hw_set,
    input logic [REG_W-1:0] impl
  );
    logic [REG_W-1:0] lane;
    logic [REG_W-1:0] res;
    lane = {{8{be[LANE_HI]}}, {8{be[LANE_LO]}}};
    res = cur;
    if (wr) begin
      res = (cur & ~lane) | (wd & lane);
    end
    return (res | hw_set) & impl;
  endfunction

  function automatic ifcb_reg_e decode(input logic [ADR_W-1:0] adr);
    ifcb_reg_e r;
    case (adr)
      OFS_TRAP: r = REG_TRAP;
      OFS_VEC: r = REG_VEC;
      OFS_FLAG0: r = REG_F0;
      OFS_FLAG1: r = REG_F1;
      OFS_FLAG2: r = REG_F2;
      OFS_EVT_STAT: r = REG_STAT;
      OFS_EVT_MASK: r = REG_MASK;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction

  // bus side
  logic ack_ff;
  logic [DATA_W-1:0] rdat_ff;
  logic [DATA_W-1:0] nxt_rdat;
  logic req;
  logic wr_commit;
  ifcb_reg_e sel_reg;
  logic [REG_W-1:0] wdat;
  logic [1:0] wbe;

  // register state
  logic [REG_W-1:0] trap_ff;
  logic [REG_W-1:0] nxt_trap;
  logic alt_vec_ff;
  logic timed_dis_ff;
  logic [EXT_N-1:0] ext_sel_ff;
  logic [REG_W-1:0] nxt_vec;
  logic [REG_W-1:0] vec_rd;
  logic [REG_W-1:0] flag0_ff;
  logic [REG_W-1:0] flag1_ff;
  logic [REG_W-1:0] flag2_ff;
  logic [REG_W-1:0] nxt_flag0;
  logic [REG_W-1:0] nxt_flag1;
  logic [REG_W-1:0] nxt_flag2;
  logic [EVT_N-1:0] stat_ff;
  logic [EVT_N-1:0] mask_ff;
  logic [EVT_N-1:0] nxt_stat;
  logic [EVT_N-1:0] evt;
  logic irq_ff;

  // hardware set sources
  logic [EXT_N-1:0] ext_edge;
  logic [REG_W-1:0] set0;
  logic [REG_W-1:0] set1;
  logic [REG_W-1:0] set2;
  logic [REG_W-1:0] trap_set;
  logic [REG_W-1:0] ext_set0;
  logic [REG_W-1:0] ext_set1;

  ifcb_ext_edge #(
    .N(EXT_N)
  ) u_ext_edge (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .pin_i(EXT_IRQ_PIN_I),
    .falling_sel_i(ext_sel_ff),
    .edge_o(ext_edge)
  );

  // wishbone classic: ack one cycle after the strobe, dropped the cycle after
  assign req = WB_CYC_I & WB_STB_I;
  assign wr_commit = req & WB_WE_I & ack_ff;
  assign sel_reg = decode(WB_ADR_I);
  assign wdat = WB_DAT_I[REG_W-1:0];
  assign wbe = WB_SEL_I[1:0];

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // read data sampled at the request edge; unmapped reads give zero
  always_comb begin
    nxt_rdat = '0;
    case (sel_reg)
      REG_TRAP: nxt_rdat[REG_W-1:0] = trap_ff & TRAP_IMPL;
      REG_VEC: nxt_rdat[REG_W-1:0] = vec_rd;
      REG_F0: nxt_rdat[REG_W-1:0] = flag0_ff;
      REG_F1: nxt_rdat[REG_W-1:0] = flag1_ff;
      REG_F2: nxt_rdat[REG_W-1:0] = flag2_ff;
      REG_STAT: nxt_rdat[EVT_N-1:0] = stat_ff;
      REG_MASK: nxt_rdat[EVT_N-1:0] = mask_ff;
      default: nxt_rdat = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      rdat_ff <= '0;
    end else if (req & ~ack_ff) begin
      rdat_ff <= nxt_rdat;
    end
  end

  // trap status: set by the core's trap pulses, software may write either way
  always_comb begin
    trap_set = '0;
    trap_set[ADDR_FAULT_BIT] = TRAP_EVT_I.addr_fault;
    trap_set[STACK_FAULT_BIT] = TRAP_EVT_I.stack_fault;
    trap_set[CLOCK_LOSS_BIT] = TRAP_EVT_I.clock_loss;
  end

  assign nxt_trap = merge_wr(trap_ff, wdat, wbe, wr_commit && (sel_reg == REG_TRAP),
    trap_set, TRAP_IMPL);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      trap_ff <= REG_RST;
    end else begin
      trap_ff <= nxt_trap;
    end
  end

  // vector/edge control; the disable bit ignores writes
  assign nxt_vec = merge_wr({alt_vec_ff, 1'b0, 9'h000, ext_sel_ff}, wdat, wbe,
    wr_commit && (sel_reg == REG_VEC), '0, VEC_WR_IMPL);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      alt_vec_ff <= 1'b0;
      ext_sel_ff <= '0;
    end else begin
      alt_vec_ff <= nxt_vec[ALT_VEC_BIT];
      ext_sel_ff <= nxt_vec[EXT_SEL_LSB +: EXT_N];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      timed_dis_ff <= 1'b0;
    end else begin
      timed_dis_ff <= TIMED_DISABLE_I;
    end
  end

  always_comb begin
    vec_rd = '0;
    vec_rd[ALT_VEC_BIT] = alt_vec_ff;
    vec_rd[TIMED_DIS_BIT] = timed_dis_ff;
    vec_rd[EXT_SEL_LSB +: EXT_N] = ext_sel_ff;
  end

  // external pin edges land on their flag positions
  always_comb begin
    ext_set0 = '0;
    ext_set1 = '0;
    ext_set0[F0_EXT0_BIT] = ext_edge[0];
    ext_set1[F1_EXT1_BIT] = ext_edge[1];
    ext_set1[F1_EXT2_BIT] = ext_edge[2];
  end

  // peripheral lines arrive already in register bit order
  assign set0 = PERIPH_EVT_I.f0 | ext_set0;
  assign set1 = PERIPH_EVT_I.f1 | ext_set1;
  assign set2 = PERIPH_EVT_I.f2;

  // sticky: a request keeps the flag until software writes zero, set beats clear
  assign nxt_flag0 = merge_wr(flag0_ff, wdat, wbe, wr_commit && (sel_reg == REG_F0),
    set0, FLAG0_IMPL);
  assign nxt_flag1 = merge_wr(flag1_ff, wdat, wbe, wr_commit && (sel_reg == REG_F1),
    set1, FLAG1_IMPL);
  assign nxt_flag2 = merge_wr(flag2_ff, wdat, wbe, wr_commit && (sel_reg == REG_F2),
    set2, FLAG2_IMPL);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      flag0_ff <= REG_RST;
      flag1_ff <= REG_RST;
      flag2_ff <= REG_RST;
    end else begin
      flag0_ff <= nxt_flag0;
      flag1_ff <= nxt_flag1;
      flag2_ff <= nxt_flag2;
    end
  end

  // summary events for the interrupt output
  always_comb begin
    evt = '0;
    evt[EVT_FLAG] = |(set0 & FLAG0_IMPL) | |(set1 & FLAG1_IMPL) | |(set2 & FLAG2_IMPL);
    evt[EVT_TRAP] = |(trap_set & TRAP_IMPL);
    evt[EVT_EXT] = |ext_edge;
  end

  // write-one-to-clear; an event in the same cycle keeps the bit set
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_commit && (sel_reg == REG_STAT) && wbe[LANE_LO]) begin
      nxt_stat = stat_ff & ~wdat[EVT_N-1:0];
    end
    nxt_stat = nxt_stat | evt;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      stat_ff <= EVT_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      mask_ff <= EVT_RST;
    end else if (wr_commit && (sel_reg == REG_MASK) && wbe[LANE_LO]) begin
      mask_ff <= wdat[EVT_N-1:0];
    end
  end

  // registered so the output is glitch free; lags the status by one cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // edges of pins 3 and 4 go to flag registers outside this bank
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      EXT_EDGE_O <= '0;
    end else begin
      EXT_EDGE_O <= ext_edge;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;
  assign IRQ_O = irq_ff;
  assign ALT_VECTOR_SEL_O = alt_vec_ff;
  assign FLAGS_O.f0 = flag0_ff;
  assign FLAGS_O.f1 = flag1_ff;
  assign FLAGS_O.f2 = flag2_ff;
  assign TRAP_FLAGS_O.addr_fault = trap_ff[ADDR_FAULT_BIT];
  assign TRAP_FLAGS_O.stack_fault = trap_ff[STACK_FAULT_BIT];
  assign TRAP_FLAGS_O.clock_loss = trap_ff[CLOCK_LOSS_BIT];

endmodule

// ---- hw/ifcb_pkg.sv ----
// package: register map, field positions and carriers of the interrupt flag bank
package ifcb_pkg;

  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADR_W = 8;
  localparam int SEL_W = 4;
  localparam int EXT_N = 5;
  localparam int TRAP_N = 3;
  localparam int EVT_N = 3;

  // byte addresses of the word registers
  localparam logic [ADR_W-1:0] OFS_TRAP = 8'h00;
  localparam logic [ADR_W-1:0] OFS_VEC = 8'h04;
  localparam logic [ADR_W-1:0] OFS_FLAG0 = 8'h08;
  localparam logic [ADR_W-1:0] OFS_FLAG1 = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_FLAG2 = 8'h10;
  localparam logic [ADR_W-1:0] OFS_EVT_STAT = 8'h14;
  localparam logic [ADR_W-1:0] OFS_EVT_MASK = 8'h18;

  // trap_control_status_1 fields
  localparam int TRAP_LSB = 1;
  localparam int ADDR_FAULT_BIT = 3;
  localparam int STACK_FAULT_BIT = 2;
  localparam int CLOCK_LOSS_BIT = 1;

  // vector_edge_control_2 fields
  localparam int ALT_VEC_BIT = 15;
  localparam int TIMED_DIS_BIT = 14;
  localparam int EXT_SEL_LSB = 0;

  // implemented-bit masks; everything outside reads zero except the read-only timed disable bit 14 outside VEC_WR_IMPL
  localparam logic [REG_W-1:0] TRAP_IMPL = 16'h000e;
  localparam logic [REG_W-1:0] VEC_WR_IMPL = 16'h801f;
  localparam logic [REG_W-1:0] FLAG0_IMPL = 16'h7fff;
  localparam logic [REG_W-1:0] FLAG1_IMPL = 16'hfffb;
  localparam logic [REG_W-1:0] FLAG2_IMPL = 16'hdfff;
  localparam logic [REG_W-1:0] REG_RST = 16'h0000;

  // flag positions fed by the external pins
  localparam int F0_EXT0_BIT = 0;
  localparam int F1_EXT1_BIT = 4;
  localparam int F1_EXT2_BIT = 13;

  // event status / mask layout
  localparam int EVT_FLAG = 0;
  localparam int EVT_TRAP = 1;
  localparam int EVT_EXT = 2;
  localparam logic [EVT_N-1:0] EVT_RST = 3'h0;

  // byte lanes
  localparam int LANE_LO = 0;
  localparam int LANE_HI = 1;

  typedef struct packed {
    logic [REG_W-1:0] f2;
    logic [REG_W-1:0] f1;
    logic [REG_W-1:0] f0;
  } ifcb_flags_s;

  typedef struct packed {
    logic addr_fault;
    logic stack_fault;
    logic clock_loss;
  } ifcb_trap_s;

  typedef enum logic [2:0] {
    REG_TRAP = 3'h0,
    REG_VEC = 3'h1,
    REG_F0 = 3'h3,
    REG_F1 = 3'h2,
    REG_F2 = 3'h6,
    REG_STAT = 3'h7,
    REG_MASK = 3'h5,
    REG_NONE = 3'h4
  } ifcb_reg_e;

endpackage

// ---- hw/ifcb_ext_edge.sv ----
// external interrupt pin synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
module ifcb_ext_edge #(
  parameter int N = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] pin_i,
  input wire logic [N-1:0] falling_sel_i,
  output logic [N-1:0] edge_o
);

  logic [N-1:0] sync1_ff;
  logic [N-1:0] sync2_ff;
  logic [N-1:0] prev_ff;
  logic [1:0] arm_ff;
  logic armed;
  logic [N-1:0] nxt_edge;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // hold off until the pipeline holds real pin levels, else a high pin fakes a rise
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arm_ff <= 2'h0;
    end else if (!armed) begin
      arm_ff <= arm_ff + 2'h1;
    end
  end

  assign armed = (arm_ff == 2'h3);

  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (falling_sel_i[i]) begin
        nxt_edge[i] = armed & prev_ff[i] & ~sync2_ff[i];
      end else begin
        nxt_edge[i] = armed & ~prev_ff[i] & sync2_ff[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      edge_o <= '0;
    end else begin
      edge_o <= nxt_edge;
    end
  end

endmodule

// ---- tb/ifcb_src_model.sv ----
// peripheral and trap event sources facing the flag bank
`timescale 1ns/1ps
module ifcb_src_model
  import ifcb_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [47:0] evt_i,
  input wire logic [2:0] trap_i,
  output ifcb_flags_s evt_o = '0,
  output ifcb_trap_s trap_o = '0
);
  // sources request for one cycle only, so the bank alone must remember
  always @(posedge clk_i) begin
    evt_o <= go_i ? evt_i : 48'h0;
    trap_o <= go_i ? trap_i : 3'h0;
  end
endmodule

// ---- tb/ifcb_bank_chk.sv ----
// port-level assertions of the flag bank
`timescale 1ns/1ps
module ifcb_bank_chk
  import ifcb_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire ifcb_flags_s PERIPH_EVT_I,
  input wire ifcb_trap_s TRAP_EVT_I,
  input wire logic [DATA_W-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic ALT_VECTOR_SEL_O,
  input wire logic [EXT_N-1:0] EXT_EDGE_O,
  input wire ifcb_flags_s FLAGS_O,
  input wire ifcb_trap_s TRAP_FLAGS_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [47:0] impl;
  logic [47:0] set;
  assign impl = {FLAG2_IMPL, FLAG1_IMPL, FLAG0_IMPL};
  assign set = PERIPH_EVT_I & impl;
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ans)
    else $error("ack not one cycle after request");
  a_ack_needs_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_read_hi_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_flag_sets: assert property (|set |=> (FLAGS_O & $past(set)) == $past(set))
    else $error("flag not set by request");
  a_flag_unimpl: assert property ((FLAGS_O & ~impl) == 48'h0)
    else $error("unimplemented flag set");
  a_trap_sets: assert property (|TRAP_EVT_I |=>
    (TRAP_FLAGS_O & $past(TRAP_EVT_I)) == $past(TRAP_EVT_I))
    else $error("trap bit not set");
  // writes land a cycle or two after cyc, so both cycles are excluded
  a_flag_held: assert property (!WB_CYC_I && !$past(WB_CYC_I) |=>
    (FLAGS_O & $past(FLAGS_O)) == $past(FLAGS_O))
    else $error("flag dropped without write");
  a_alt_by_write: assert property ($changed(ALT_VECTOR_SEL_O) |->
    $past(WB_CYC_I && WB_WE_I) || $past(WB_CYC_I && WB_WE_I, 2))
    else $error("vector select moved without write");
  a_edge_single: assert property (|EXT_EDGE_O |=>
    (EXT_EDGE_O & $past(EXT_EDGE_O)) == 5'h0)
    else $error("edge pulse longer than one cycle");
endmodule
bind ifcb_bank ifcb_bank_chk i_chk (.CORE_CLK_I, .RST_N_I, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .PERIPH_EVT_I, .TRAP_EVT_I, .WB_DAT_O, .WB_ACK_O, .ALT_VECTOR_SEL_O,
  .EXT_EDGE_O, .FLAGS_O, .TRAP_FLAGS_O);

// ---- tb/ifcb_bank_tb.sv ----
// testbench of the flag bank over its wishbone port
`timescale 1ns/1ps
module ifcb_bank_tb
  import ifcb_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0;
  logic go = 1'b0;
  logic [47:0] ev = 48'h0;
  logic [2:0] tr = 3'h0;
  logic dis = 1'b0;
  logic [4:0] pin = 5'h0;
  logic [3:0] sel = 4'h3;
  logic [3:0] lanes = 4'h3;
  logic [4:0] edg;
  logic [4:0] seen = 5'h0;
  ifcb_flags_s evt;
  ifcb_flags_s flg;
  ifcb_trap_s trp;
  ifcb_trap_s tfl;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic alt;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h62;
  logic [47:0] v;
  logic [15:0] impl[3] = '{FLAG0_IMPL, FLAG1_IMPL, FLAG2_IMPL};
  int failures = 0;
  int num_checks = 0;

  ifcb_src_model i_src (.clk_i(clk), .go_i(go), .evt_i(ev), .trap_i(tr), .evt_o(evt),
    .trap_o(trp));
  ifcb_bank i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .PERIPH_EVT_I(evt),
    .TRAP_EVT_I(trp), .TIMED_DISABLE_I(dis), .EXT_IRQ_PIN_I(pin), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .IRQ_O(irq), .ALT_VECTOR_SEL_O(alt), .EXT_EDGE_O(edg),
    .FLAGS_O(flg), .TRAP_FLAGS_O(tfl));

  initial forever #20 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // the request is held until ack is seen, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dat <= {16'h0, d};
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    wb(1'b0, a, 16'h0);
  endtask

  task automatic fire(input logic [47:0] e, input logic [2:0] t);
    @(posedge clk);
    go <= 1'b1;
    ev <= e;
    tr <= t;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) chk(rdat, exp_q.pop_front());
  end

  // remembers every pin that ever pulsed its edge output
  always @(posedge clk) begin
    if (rst_n) seen <= seen | edg;
  end

  initial begin
    #(40 * 10000);
    failures++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 16'h0);
    for (int r = 0; r < 3; r++) begin
      wb(1'b1, OFS_FLAG0 + 8'(r * 4), 16'hffff);
      rd(OFS_FLAG0 + 8'(r * 4), impl[r]);
      wb(1'b1, OFS_FLAG0 + 8'(r * 4), 16'h0);
      rd(OFS_FLAG0 + 8'(r * 4), 16'h0);
    end
    lanes = 4'h2;
    wb(1'b1, OFS_FLAG0, 16'hffff);
    rd(OFS_FLAG0, 16'h7f00);
    lanes = 4'h1;
    wb(1'b1, OFS_FLAG0, 16'hffff);
    rd(OFS_FLAG0, 16'h7fff);
    wb(1'b1, OFS_FLAG0, 16'h0);
    rd(OFS_FLAG0, 16'h7f00);
    lanes = 4'h3;
    wb(1'b1, OFS_FLAG0, 16'h0);
    wb(1'b1, OFS_TRAP, 16'hffff);
    rd(OFS_TRAP, TRAP_IMPL);
    wb(1'b1, OFS_TRAP, 16'h0);
    wb(1'b1, OFS_VEC, 16'hffff);
    rd(OFS_VEC, VEC_WR_IMPL);
    chk(alt, 1'b1);
    wb(1'b1, OFS_VEC, 16'h0);
    repeat (3) @(posedge clk);
    chk(alt, 1'b0);
    $display("test register access done");
    for (int i = 0; i < 48; i++) begin
      fire(48'h1 << i, 3'h0);
      rd(OFS_FLAG0 + 8'(i / 16 * 4), impl[i / 16] & (16'h1 << (i % 16)));
      wb(1'b1, OFS_FLAG0 + 8'(i / 16 * 4), 16'h0);
    end
    for (int j = 0; j < 3; j++) begin
      fire(48'h0, 3'h1 << j);
      rd(OFS_TRAP, 16'h2 << j);
      wb(1'b1, OFS_TRAP, 16'h0);
    end
    repeat (4) begin
      seed = xs(seed);
      v[47:32] = seed[15:0];
      seed = xs(seed);
      v[31:0] = seed;
      fire(v, 3'h0);
      for (int r = 0; r < 3; r++) begin
        rd(OFS_FLAG0 + 8'(r * 4), v[r * 16 +: 16] & impl[r]);
        wb(1'b1, OFS_FLAG0 + 8'(r * 4), 16'h0);
      end
    end
    $display("test event flags done");
    dis <= 1'b1;
    rd(OFS_VEC, 16'h4000);
    dis <= 1'b0;
    wb(1'b1, OFS_VEC, 16'h4000);
    rd(OFS_VEC, 16'h0);
    wb(1'b1, OFS_EVT_STAT, 16'h7);
    wb(1'b1, OFS_VEC, 16'h0002);
    pin <= 5'h1f;
    repeat (8) @(posedge clk);
    chk(seen, 5'h1d);
    rd(OFS_FLAG0, 16'h1);
    rd(OFS_FLAG1, 16'h2000);
    pin <= 5'h00;
    repeat (8) @(posedge clk);
    chk(seen, 5'h1f);
    rd(OFS_FLAG0, 16'h1);
    rd(OFS_FLAG1, 16'h2010);
    $display("test pin edges done");
    rd(OFS_EVT_STAT, 16'h5);
    chk(irq, 1'b0);
    wb(1'b1, OFS_EVT_MASK, 16'h4);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b1, OFS_EVT_STAT, 16'h5);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rd(OFS_EVT_STAT, 16'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_FLAG1, 16'h0);
    $display("test interrupt and reset done");
    results();
  end
endmodule
